// ---- logic/dds_door_drive_safety_functions.sv ----
// Purpose: supervisory open/close, park, emergency and light barrier control
// Assumes: doorPos and obstruct come from motor logic on core_clk
// Notes: commands and terminals arrive asynchronously and are synchronised
`timescale 1ns/1ps
`default_nettype none
module dds_door_drive_safety_functions #(
    parameter int POS_W = 12,
    parameter int OPEN_WIDTH_MM = 1000,
    parameter int INIT_OBST_CYC = dds_pkg::INIT_OBST_MS * dds_pkg::CYC_PER_MS,
    parameter int PARK_STALL_CYC = dds_pkg::PARK_STALL_MS * dds_pkg::CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire dds_pkg::dds_bus_t bus,
    output dds_pkg::dds_drive_t drive,
    output logic [31:0] rdata,
    output logic halted,
    input wire logic openCmd,
    input wire logic closeCmd,
    input wire logic controlInput,
    input wire logic auxInput,
    input wire logic [POS_W-1:0] doorPos,
    input wire logic obstruct
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPENING, ST_OPEN_HOLD, ST_CLOSING, ST_CLOSED_HOLD, ST_PARK, ST_HALT
    } dds_state_t;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [3:0] syncA;
    logic [3:0] syncB;

    // two stages before any logic reads the pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncA <= 4'h0;
            syncB <= 4'h0;
        end else begin
            syncA <= {auxInput, controlInput, closeCmd, openCmd};
            syncB <= syncA;
        end
    end

    wire openS = syncB[0];
    wire closeS = syncB[1];
    wire in1S = syncB[2];
    wire auxS = syncB[3];

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [3:0] triesCfg;
    logic fullOpen;
    logic auxMode;
    logic [1:0] in1Mode;
    logic [6:0] parkMm;
    logic [8:0] openForce;
    logic [3:0] weightKg;

    wire wrCtrl = bus.wr && bus.addr == dds_pkg::OFS_CTRL;
    wire wrForce = bus.wr && bus.addr == dds_pkg::OFS_FORCE;
    wire wrWeight = bus.wr && bus.addr == dds_pkg::OFS_WEIGHT;
    wire wrLearn = bus.wr && bus.addr == dds_pkg::OFS_LEARN && bus.wdata[0];

    // counterweight clamped to the allowed span
    wire [3:0] weightIn = bus.wdata[3:0];
    wire [3:0] weightClamp = (weightIn > dds_pkg::WEIGHT_MAX_KG) ?
        dds_pkg::WEIGHT_MAX_KG : weightIn;
    wire [8:0] weightForce = dds_pkg::FORCE_BASE_N +
        9'(weightClamp * dds_pkg::GRAVITY_MS2);
    wire [6:0] parkIn = bus.wdata[dds_pkg::CTL_PARK_LSB +: 7];
    wire [6:0] parkClamp = (parkIn > dds_pkg::PARK_MAX_MM) ?
        dds_pkg::PARK_MAX_MM : parkIn;

    // software configuration, defaults from reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            triesCfg <= dds_pkg::TRIES_RESET;
            fullOpen <= 1'b0;
            auxMode <= dds_pkg::AUX_EMERGENCY;
            in1Mode <= dds_pkg::IN1_BARRIER;
            parkMm <= dds_pkg::PARK_RESET;
            openForce <= dds_pkg::FORCE_RESET;
            weightKg <= 4'h0;
        end else begin
            if (wrCtrl) begin
                triesCfg <= bus.wdata[dds_pkg::CTL_TRIES_LSB +: 4];
                fullOpen <= bus.wdata[dds_pkg::CTL_FULL_BIT];
                auxMode <= bus.wdata[dds_pkg::CTL_AUX_BIT];
                parkMm <= parkClamp;
            end
            if (wrLearn) begin
                in1Mode <= dds_pkg::IN1_BARRIER;
            end else if (wrCtrl) begin
                in1Mode <= bus.wdata[dds_pkg::CTL_IN1_LSB +: 2];
            end
            if (wrWeight) begin
                weightKg <= weightClamp;
                openForce <= weightForce;
            end else if (wrForce) begin
                openForce <= bus.wdata[8:0];
            end
        end
    end

    // ************************************************************
    // derived conditions
    // ************************************************************
    wire glassActive = openForce >= dds_pkg::FORCE_BASE_N &&
        openForce <= dds_pkg::FORCE_TOP_N;
    wire barrierUsed = in1Mode == dds_pkg::IN1_BARRIER;
    // barrier takes priority: emergency input is inert while barrier is used
    wire emergUsed = auxMode == dds_pkg::AUX_EMERGENCY && !barrierUsed;
    wire feedbackUsed = auxMode == dds_pkg::AUX_FEEDBACK;
    wire sensorClosed = in1Mode == dds_pkg::IN1_CLOSED_SENSOR && in1S;
    wire wideEnough = doorPos >= POS_W'(dds_pkg::BARRIER_MIN_MM);
    wire barrierCut = barrierUsed && !in1S && wideEnough;
    wire parkOn = parkMm != 7'h00;

    logic [POS_W-1:0] parkBase;
    logic referenced;
    wire [POS_W-1:0] parkTarget = parkBase + POS_W'(parkMm);
    wire needPark = parkOn && doorPos < parkTarget;
    wire atOpen = doorPos >= POS_W'(OPEN_WIDTH_MM);
    wire atClosedNorm = referenced && (doorPos == '0 || sensorClosed);

    // ************************************************************
    // timers and edges
    // ************************************************************
    dds_state_t state;
    dds_state_t next_state;
    logic [23:0] obstCnt;
    logic [23:0] stallCnt;
    logic [POS_W-1:0] lastPos;
    logic obstPrev;
    logic [3:0] triesLeft;
    logic byBarrier;
    logic emerg;

    wire obstRise = obstruct && !obstPrev;
    wire obstLong = obstCnt >= 24'(INIT_OBST_CYC - 1);
    wire stalled = stallCnt >= 24'(PARK_STALL_CYC - 1);

    // closing obstruction and standstill counters
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            obstCnt <= 24'h0;
            stallCnt <= 24'h0;
            lastPos <= '0;
            obstPrev <= 1'b0;
        end else begin
            obstPrev <= obstruct;
            lastPos <= doorPos;
            if (state == ST_CLOSING && obstruct && !obstLong) begin
                obstCnt <= obstCnt + 24'h1;
            end else if (!(state == ST_CLOSING && obstruct)) begin
                obstCnt <= 24'h0;
            end
            if (state == ST_PARK && doorPos == lastPos && !stalled) begin
                stallCnt <= stallCnt + 24'h1;
            end else if (!(state == ST_PARK && doorPos == lastPos)) begin
                stallCnt <= 24'h0;
            end
        end
    end

    // ************************************************************
    // door sequence
    // ************************************************************
    // de-energising goes through park travel when short of the park point
    wire dds_state_t offState = needPark ? ST_PARK : ST_IDLE;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (openS) begin
                    next_state = ST_OPENING;
                end else if (closeS && !barrierCut) begin
                    next_state = ST_CLOSING;
                end
            end
            ST_OPENING: begin
                if (obstRise && triesLeft == 4'h0) begin
                    next_state = ST_HALT;
                end else if (atOpen) begin
                    next_state = ST_OPEN_HOLD;
                end else if (byBarrier && !fullOpen && !barrierCut && closeS) begin
                    next_state = ST_CLOSING;
                end else if (!byBarrier && !openS) begin
                    next_state = closeS ? ST_CLOSING : offState;
                end
            end
            ST_OPEN_HOLD: begin
                if (!openS && closeS && !barrierCut) begin
                    next_state = ST_CLOSING;
                end else if (!openS && !closeS) begin
                    next_state = offState;
                end
            end
            ST_CLOSING: begin
                if (openS || (closeS && barrierCut)) begin
                    next_state = ST_OPENING;
                end else if (!referenced && obstLong) begin
                    next_state = ST_CLOSED_HOLD;
                end else if (atClosedNorm) begin
                    next_state = ST_CLOSED_HOLD;
                end else if (!closeS) begin
                    next_state = offState;
                end
            end
            ST_CLOSED_HOLD: begin
                if (openS) begin
                    next_state = ST_OPENING;
                end else if (!closeS) begin
                    next_state = offState;
                end
            end
            ST_PARK: begin
                if (doorPos >= parkTarget || stalled) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (!openS) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    wire obstInitDone = state == ST_CLOSING && !referenced && obstLong;

    // state, reference point, retries and reversal reason
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            referenced <= 1'b0;
            parkBase <= '0;
            triesLeft <= dds_pkg::TRIES_RESET;
            byBarrier <= 1'b0;
        end else begin
            state <= next_state;
            if (obstInitDone) begin
                referenced <= 1'b1;
                parkBase <= doorPos;
            end
            if (state == ST_OPENING && obstRise && triesLeft != 4'h0) begin
                triesLeft <= triesLeft - 4'h1;
            end else if (state != ST_OPENING && next_state == ST_OPENING) begin
                triesLeft <= triesCfg;
            end
            if (state == ST_CLOSING && next_state == ST_OPENING) begin
                byBarrier <= !openS;
            end else if (next_state != ST_OPENING) begin
                byBarrier <= 1'b0;
            end
        end
    end

    // ************************************************************
    // emergency power mode
    // ************************************************************
    wire endReached = state == ST_CLOSED_HOLD || state == ST_OPEN_HOLD;

    // entry wins over exit; exit only at an end position
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            emerg <= 1'b0;
        end else if (emergUsed && auxS) begin
            emerg <= 1'b1;
        end else if (endReached) begin
            emerg <= 1'b0;
        end
    end

    // ************************************************************
    // drive command
    // ************************************************************
    dds_pkg::dds_drive_t next_drive;

    always_comb begin
        next_drive.motorOn = next_state != ST_IDLE && next_state != ST_HALT;
        next_drive.dirOpen = next_state == ST_OPENING || next_state == ST_OPEN_HOLD ||
            next_state == ST_PARK;
        next_drive.staticForce = next_state == ST_PARK;
        if (next_state == ST_PARK) begin
            next_drive.speed = dds_pkg::SPD_SLOW;
        end else if (emerg) begin
            next_drive.speed = dds_pkg::SPD_REDUCED;
        end else if (next_state == ST_CLOSING && feedbackUsed && !auxS) begin
            next_drive.speed = dds_pkg::SPD_NUDGE;
        end else begin
            next_drive.speed = dds_pkg::SPD_MAX;
        end
    end

    // ************************************************************
    // read port and registered outputs
    // ************************************************************
    wire [31:0] ctrlView = {17'h0, parkMm, in1Mode, auxMode, fullOpen, triesCfg};
    wire [31:0] statView = {19'h0, barrierCut, triesLeft, 1'b0, referenced,
        emerg, glassActive, 1'b0, state};
    wire [31:0] readMux = (bus.addr == dds_pkg::OFS_CTRL) ? ctrlView :
        (bus.addr == dds_pkg::OFS_FORCE) ? {23'h0, openForce} :
        (bus.addr == dds_pkg::OFS_WEIGHT) ? {28'h0, weightKg} :
        (bus.addr == dds_pkg::OFS_STATUS) ? statView : 32'h0;

    // outputs straight from flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drive <= '0;
            rdata <= 32'h0;
            halted <= 1'b0;
        end else begin
            drive <= next_drive;
            rdata <= bus.rd ? readMux : 32'h0;
            halted <= next_state == ST_HALT;
        end
    end
endmodule
`default_nettype wire

// ---- logic/dds_pkg.sv ----
// Purpose: shared constants and types for the door drive safety block
// Assumes: 10 MHz core clock, door position in millimetres from closed
// Notes: register offsets are byte addresses on a 32-bit plain port
`default_nettype none
package dds_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_HZ = 10000000;
    localparam int INIT_OBST_MS = 1000; // closing obstruction taken as closed
    localparam int PARK_STALL_MS = 300; // standstill during park travel
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FORCE = 8'h04;
    localparam logic [7:0] OFS_WEIGHT = 8'h08;
    localparam logic [7:0] OFS_LEARN = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int CTL_TRIES_LSB = 0; // 4 bits, opening attempts
    localparam int CTL_FULL_BIT = 4; // full opening on barrier interruption
    localparam int CTL_AUX_BIT = 5; // aux terminal: 0 emergency, 1 feedback
    localparam int CTL_IN1_LSB = 6; // 2 bits, control input pin 5/6 use
    localparam int CTL_PARK_LSB = 8; // 7 bits, park distance in mm
    localparam logic [3:0] TRIES_RESET = 4'h3;
    localparam logic [6:0] PARK_RESET = 7'h00;
    localparam logic [6:0] PARK_MAX_MM = 7'h64; // 100 mm
    localparam logic [1:0] IN1_BARRIER = 2'h0;
    localparam logic [1:0] IN1_CLOSED_SENSOR = 2'h1;
    localparam logic [1:0] IN1_OFF = 2'h2;
    localparam logic AUX_EMERGENCY = 1'b0;
    localparam logic AUX_FEEDBACK = 1'b1;

    // ************************************************************
    // force and barrier figures
    // ************************************************************
    localparam logic [8:0] FORCE_BASE_N = 9'h096; // 150 N
    localparam logic [8:0] FORCE_TOP_N = 9'h0e6; // 230 N
    localparam logic [3:0] WEIGHT_MAX_KG = 4'h8;
    localparam logic [8:0] GRAVITY_MS2 = 9'h00a; // 10 m/s2
    localparam logic [8:0] FORCE_RESET = 9'h096;
    localparam int BARRIER_MIN_MM = 10; // 1 cm

    // ************************************************************
    // status register fields
    // ************************************************************
    localparam int ST_STATE_LSB = 0; // 3 bits
    localparam int ST_GLASS_BIT = 4;
    localparam int ST_EMERG_BIT = 5;
    localparam int ST_REF_BIT = 6;
    localparam int ST_TRIES_LSB = 8; // 4 bits
    localparam int ST_BARRIER_BIT = 12;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {SPD_MAX, SPD_SLOW, SPD_REDUCED, SPD_NUDGE} dds_speed_t;

    typedef struct packed {
        logic motorOn;
        logic dirOpen;
        logic staticForce;
        dds_speed_t speed;
    } dds_drive_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dds_bus_t;
endpackage
`default_nettype wire

// ---- sim/dds_door_drive_safety_functions_asserts.sv ----
// Purpose: port checker for the door drive safety block
// Assumes: bound to the top module, one clock domain
// Notes: shadows the force figure from bus writes
`timescale 1ns/1ps
`default_nettype none
module dds_door_drive_safety_functions_asserts #(
    parameter int POS_W = 12,
    parameter int OPEN_WIDTH_MM = 1000,
    parameter int PARK_STALL_CYC = 3000000
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire dds_pkg::dds_bus_t bus,
    input wire dds_pkg::dds_drive_t drive,
    input wire logic [31:0] rdata,
    input wire logic halted,
    input wire logic openCmd,
    input wire logic closeCmd,
    input wire logic [POS_W-1:0] doorPos
);
    // ************************************************************
    // helper logic and properties
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [8:0] forceN;
    int stall;
    wire logic [3:0] kg = (bus.wdata[3:0] > 4'h8) ? 4'h8 : bus.wdata[3:0];
    wire logic glassOk = forceN >= 9'h096 && forceN <= 9'h0e6;
    // force shadow and park standstill count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            forceN <= dds_pkg::FORCE_RESET;
            stall <= 0;
        end else begin
            if (bus.wr && bus.addr == dds_pkg::OFS_FORCE) forceN <= bus.wdata[8:0];
            if (bus.wr && bus.addr == dds_pkg::OFS_WEIGHT) forceN <= 9'h096 + 9'h00a * kg;
            stall <= (drive.staticForce && doorPos == $past(doorPos)) ? stall + 1 : 0;
        end
    end
    sequence openQuiet;
        (!drive.motorOn && !closeCmd && doorPos < OPEN_WIDTH_MM) [*4];
    endsequence
    sequence startOpen;
        !drive.motorOn [*2] ##[1:2] (drive.motorOn && drive.dirOpen);
    endsequence
    rdata_idle_a:
    assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("rdata not idle");
    force_read_a:
    assert property (bus.rd && bus.addr == dds_pkg::OFS_FORCE |=> rdata == {23'h0, $past(forceN)})
        else $error("force readback wrong");
    glass_flag_a:
    assert property (bus.rd && bus.addr == dds_pkg::OFS_STATUS |=> rdata[4] == $past(glassOk))
        else $error("glass flag wrong");
    park_clamp_a:
    assert property (bus.rd && bus.addr == dds_pkg::OFS_CTRL |=> rdata[14:8] <= 7'h64)
        else $error("park distance above limit");
    park_profile_a:
    assert property (drive.staticForce |-> drive.motorOn && drive.dirOpen
        && drive.speed == dds_pkg::SPD_SLOW) else $error("park travel profile wrong");
    park_stall_a:
    assert property (stall <= PARK_STALL_CYC + 4) else $error("park standstill too long");
    halt_stop_a:
    assert property (halted |-> !drive.motorOn) else $error("motor on while halted");
    open_start_a:
    assert property (openQuiet ##0 $rose(openCmd) |=> startOpen) else $error("open latency wrong");
endmodule
`default_nettype wire

// ---- sim/dds_door_motor.sv ----
// Purpose: door motor model with position count and obstruction
// Assumes: door moves 1 mm every STEP clocks while energised
// Notes: jam stalls the door; closed end stop counts as obstruction
`timescale 1ns/1ps
`default_nettype none
module dds_door_motor #(
    parameter int WIDTH = 60,
    parameter int STEP = 4,
    parameter int START = 30
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire dds_pkg::dds_drive_t drive,
    input wire logic jam,
    output logic [11:0] doorPos,
    output logic obstruct
);
    // ************************************************************
    // travel
    // ************************************************************
    int tick;
    wire logic atEnd = drive.dirOpen ? doorPos >= WIDTH : doorPos == 12'h000;
    // blocked while energised against a jam or the closed stop
    assign obstruct = drive.motorOn && (jam || (!drive.dirOpen && doorPos == 12'h000));
    // one step per STEP clocks of free travel
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick <= 0;
            doorPos <= 12'(START);
        end else if (drive.motorOn && !jam && !atEnd) begin
            tick <= (tick == STEP - 1) ? 0 : tick + 1;
            if (tick == STEP - 1) begin
                doorPos <= drive.dirOpen ? doorPos + 12'h001 : doorPos - 12'h001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb_door_drive_safety_functions.sv ----
// Purpose: self-checking bench for the door drive safety block
// Assumes: motor model opens to 60 mm, timers shortened
// Notes: expectations computed with integers from the settings written
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module tb_door_drive_safety_functions;
    // ************************************************************
    // stimulus and checks
    // ************************************************************
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    dds_pkg::dds_bus_t bus = '0;
    dds_pkg::dds_drive_t drive;
    logic [31:0] rdata, d;
    logic [11:0] doorPos;
    logic halted, obstruct;
    logic openCmd = 1'b0, closeCmd = 1'b0, controlInput = 1'b1, auxInput = 1'b0, jam = 1'b0;
    int mismatches = 0, totalChecks = 0, cycles = 0, f, p;
    int fv[4] = '{149, 150, 230, 231};
    dds_door_drive_safety_functions #(.OPEN_WIDTH_MM(60), .INIT_OBST_CYC(20),
        .PARK_STALL_CYC(10)) i_dds_door_drive_safety_functions (.core_clk(core_clk),
        .rst(rst), .bus(bus), .drive(drive), .rdata(rdata), .halted(halted),
        .openCmd(openCmd), .closeCmd(closeCmd), .controlInput(controlInput),
        .auxInput(auxInput), .doorPos(doorPos), .obstruct(obstruct));
    dds_door_motor #(.WIDTH(60)) i_dds_door_motor (.core_clk(core_clk), .rst(rst),
        .drive(drive), .jam(jam), .doorPos(doorPos), .obstruct(obstruct));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
        // idle cycle so the next task never rewrites the bus in this step
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(posedge core_clk);
        d = rdata; // taken at the edge that closes the data cycle
    endtask
    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask
    task automatic goTo(input int t);
        int n;
        n = 0;
        while (doorPos !== 12'(t) && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("doorPos", t, doorPos)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // cycle ceiling against hangs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'hf90f));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(dds_pkg::OFS_CTRL);
        `CHK("ctrl", 32'h3, d)
        rd(8'h14);
        `CHK("unmapped", 0, d)
        for (int k = 0; k < 10; k++) begin
            wr(dds_pkg::OFS_WEIGHT, k);
            rd(dds_pkg::OFS_FORCE);
            `CHK("force", 150 + 10 * (k > 8 ? 8 : k), d)
        end
        for (int k = 0; k < 8; k++) begin
            f = k < 4 ? fv[k] : $urandom % 512;
            wr(dds_pkg::OFS_FORCE, f);
            rd(dds_pkg::OFS_STATUS);
            `CHK("glass", f >= 150 && f <= 230, d[4])
        end
        for (int k = 0; k < 2; k++) begin
            p = k ? $urandom % 128 : 101;
            wr(dds_pkg::OFS_CTRL, (p << 8) | 3);
            rd(dds_pkg::OFS_CTRL);
            `CHK("park", ((p > 100 ? 100 : p) << 8) | 3, d)
        end
        wr(dds_pkg::OFS_CTRL, 32'h83);
        wr(dds_pkg::OFS_LEARN, 32'h1);
        rd(dds_pkg::OFS_CTRL);
        `CHK("input use", 0, d[7:6])
        $display("test 1 done");
        wr(dds_pkg::OFS_CTRL, 32'h1403);
        closeCmd <= 1'b1;
        goTo(0);
        repeat (30) @(posedge core_clk);
        rd(dds_pkg::OFS_STATUS);
        `CHK("closed", 32'h44, d & 32'h47)
        closeCmd <= 1'b0;
        settle();
        `CHK("park", 3'h7, {drive.motorOn, drive.dirOpen, drive.staticForce})
        goTo(20);
        settle();
        `CHK("park stop", 20, {drive.motorOn, doorPos})
        $display("test 2 done");
        openCmd <= 1'b1;
        goTo(60);
        openCmd <= 1'b0;
        closeCmd <= 1'b1;
        goTo(40);
        controlInput <= 1'b0;
        settle();
        `CHK("reverse", 2'h3, {drive.motorOn, drive.dirOpen})
        controlInput <= 1'b1;
        settle();
        `CHK("reclose", 2'h2, {drive.motorOn, drive.dirOpen})
        goTo(5);
        controlInput <= 1'b0;
        settle();
        `CHK("near closed", 2'h2, {drive.motorOn, drive.dirOpen})
        goTo(0);
        settle();
        closeCmd <= 1'b0;
        goTo(20);
        settle();
        rd(dds_pkg::OFS_STATUS);
        `CHK("idle", 0, d[2:0])
        controlInput <= 1'b1;
        settle();
        controlInput <= 1'b0;
        settle();
        rd(dds_pkg::OFS_STATUS);
        `CHK("state", 0, d[2:0])
        closeCmd <= 1'b1;
        settle();
        `CHK("no close", 1'b0, drive.motorOn && !drive.dirOpen)
        closeCmd <= 1'b0;
        controlInput <= 1'b1;
        settle();
        $display("test 3 done");
        for (int t = 0; t < 2; t++) begin
            wr(dds_pkg::OFS_CTRL, t);
            openCmd <= 1'b1;
            settle();
            for (int n = 0; n <= t; n++) begin
                jam <= 1'b1;
                settle();
                jam <= 1'b0;
                settle();
                `CHK("halted", n == t, halted)
            end
            openCmd <= 1'b0;
            settle();
        end
        $display("test 4 done");
        wr(dds_pkg::OFS_CTRL, 32'h83);
        auxInput <= 1'b1;
        openCmd <= 1'b1;
        settle();
        `CHK("emergency", dds_pkg::SPD_REDUCED, drive.speed)
        auxInput <= 1'b0;
        settle();
        `CHK("emergency held", dds_pkg::SPD_REDUCED, drive.speed)
        goTo(60);
        settle();
        rd(dds_pkg::OFS_STATUS);
        `CHK("emergency left", 0, d[5])
        for (int m = 0; m < 3; m++) begin
            wr(dds_pkg::OFS_CTRL, m == 0 ? 32'h3 : 32'h23);
            auxInput <= m != 2;
            openCmd <= 1'b0;
            closeCmd <= 1'b1;
            settle();
            `CHK("speed", m == 2 ? dds_pkg::SPD_NUDGE : dds_pkg::SPD_MAX, drive.speed)
        end
        // full opening on: a cleared barrier keeps the door opening
        goTo(30);
        wr(dds_pkg::OFS_CTRL, 32'h13);
        controlInput <= 1'b0;
        settle();
        controlInput <= 1'b1;
        settle();
        `CHK("full open", 2'h3, {drive.motorOn, drive.dirOpen})
        goTo(60);
        $display("test 5 done");
        tally_and_finish();
    end
endmodule
bind dds_door_drive_safety_functions dds_door_drive_safety_functions_asserts #(.POS_W(POS_W),
    .OPEN_WIDTH_MM(OPEN_WIDTH_MM), .PARK_STALL_CYC(PARK_STALL_CYC)) i_chk (.core_clk(core_clk),
    .rst(rst), .bus(bus), .drive(drive), .rdata(rdata), .halted(halted), .openCmd(openCmd),
    .closeCmd(closeCmd), .doorPos(doorPos));
`default_nettype wire
